// >>> src/int_prio_params.svh
// register offsets, field positions, reset values for the priority select
`ifndef INT_PRIO_PARAMS_SVH
`define INT_PRIO_PARAMS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IPS_IDX_LO_A      12'h0B8
`define IPS_IDX_HI_A      12'h0B9
`define IPS_IDX_LO_B      12'h0F8
`define IPS_IDX_HI_B      12'h0F9
`define IPS_IDX_NMI_STAT  12'h0F7
`define IPS_ADDR_LO_A     (`IPS_IDX_LO_A << 2)
`define IPS_ADDR_HI_A     (`IPS_IDX_HI_A << 2)
`define IPS_ADDR_LO_B     (`IPS_IDX_LO_B << 2)
`define IPS_ADDR_HI_B     (`IPS_IDX_HI_B << 2)
`define IPS_ADDR_NMI_STAT (`IPS_IDX_NMI_STAT << 2)
`define IPS_ADDR_CCU_PTR  12'h000
`define IPS_ADDR_IRQ_STAT 12'h004
`define IPS_ADDR_IRQ_MASK 12'h008
`define IPS_ADDR_CORE     12'h00C

// ----------------------------------------------------------------------
// field layout and sizes
// ----------------------------------------------------------------------
`define IPS_NODES         14
`define IPS_NODES_A       6
`define IPS_NODES_B       8
`define IPS_CCU_FIRST     10
`define IPS_CCU_NODES     4
`define IPS_NMI_SRCS      8
`define IPS_IRQ_EVENTS    3
`define IPS_EV_VECTOR     0
`define IPS_EV_PREEMPT    1
`define IPS_EV_NMI        2
`define IPS_RANK_NMI      3'h5
`define IPS_AUTOCLR_MASK  14'h000F

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IPS_RST_LO_A      6'h00
`define IPS_RST_HI_A      6'h00
`define IPS_RST_LO_B      8'h00
`define IPS_RST_HI_B      8'h04
`define IPS_RST_CCU_PTR   8'hE4
`define IPS_RST_IRQ_MASK  3'h0

`endif

// >>> src/int_prio_pkg.sv
// types shared by the interrupt priority select files
package int_prio_pkg;
  typedef logic [1:0] level_t;
  typedef logic [3:0] node_t;
  typedef logic [2:0] rank_t;
endpackage

// >>> src/int_prio_select.sv
// interrupt priority select: level registers, flags, arbitration, apb
`timescale 1ns/10ps
`include "int_prio_params.svh"
module int_prio_select
  import int_prio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output      logic        pready,
  output      logic [31:0] prdata,
  output      logic        pslverr,
  // peripheral request flags, one per node
  input  wire logic [13:0] periphFlags,
  // capture/compare unit sources
  input  wire logic [3:0]  ccuSrc,
  // non-maskable event pulses
  input  wire logic [7:0]  nmiEvent,
  // processor core side
  output      logic        intReq,
  output      logic        nmiReq,
  output      node_t       intNode,
  output      level_t      intLevel,
  input  wire logic        intAck,
  input  wire logic        intReti,
  // flag clear pulses back to the peripherals
  output      logic [13:0] vectorClr,
  // interrupt line
  output      logic        irq
);

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rstSync1_q;
  logic rstSync2_q;
  wire  rstnSync = rstSync2_q;

  // two-stage release of the asynchronous reset
  // other flops reset on this copy, so release never hits a setup window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  wire accessPh  = psel & penable;
  wire takeNow   = accessPh & pready_q;
  wire wrNow     = takeNow & pwrite;
  wire laneZero  = pstrb[0];
  // register selects on the byte address, four times the index
  wire selLoA    = (paddr == `IPS_ADDR_LO_A);
  wire selHiA    = (paddr == `IPS_ADDR_HI_A);
  wire selLoB    = (paddr == `IPS_ADDR_LO_B);
  wire selHiB    = (paddr == `IPS_ADDR_HI_B);
  wire selNmi    = (paddr == `IPS_ADDR_NMI_STAT);
  wire selPtr    = (paddr == `IPS_ADDR_CCU_PTR);
  wire selIrqSt  = (paddr == `IPS_ADDR_IRQ_STAT);
  wire selIrqMk  = (paddr == `IPS_ADDR_IRQ_MASK);
  wire selCore   = (paddr == `IPS_ADDR_CORE);
  wire mapped    = selLoA | selHiA | selLoB | selHiB | selNmi |
                   selPtr | selIrqSt | selIrqMk | selCore;
  wire wrOk      = wrNow & mapped & laneZero;
  wire [7:0] wrByte = pwdata[7:0];

  // ----------------------------------------------------------------------
  // priority level registers
  // ----------------------------------------------------------------------
  logic [5:0] loA_q;
  logic [5:0] hiA_q;
  logic [7:0] loB_q;
  logic [7:0] hiB_q;
  logic [7:0] ccuPtr_q;
  logic [2:0] irqMask_q;

  // software writes, reserved bits 7:6 of the first pair are not kept
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      loA_q     <= `IPS_RST_LO_A;
      hiA_q     <= `IPS_RST_HI_A;
      loB_q     <= `IPS_RST_LO_B;
      hiB_q     <= `IPS_RST_HI_B;
      ccuPtr_q  <= `IPS_RST_CCU_PTR;
      irqMask_q <= `IPS_RST_IRQ_MASK;
    end else begin
      if (wrOk && selLoA) begin
        loA_q <= wrByte[5:0];
      end
      if (wrOk && selHiA) begin
        hiA_q <= wrByte[5:0];
      end
      if (wrOk && selLoB) begin
        loB_q <= wrByte;
      end
      if (wrOk && selHiB) begin
        hiB_q <= wrByte;
      end
      if (wrOk && selPtr) begin
        ccuPtr_q <= wrByte;
      end
      if (wrOk && selIrqMk) begin
        irqMask_q <= wrByte[2:0];
      end
    end
  end

  // node order: first pair holds nodes 0-5, second pair nodes 6-13
  wire [13:0] lvlLow  = {loB_q, loA_q};
  wire [13:0] lvlHigh = {hiB_q, hiA_q};

  // ----------------------------------------------------------------------
  // request flag sampling and capture/compare routing
  // ----------------------------------------------------------------------
  logic [13:0] flags_q;
  logic [3:0]  ccuSrc_q;

  // flags are read where they live, once per clock
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      flags_q  <= 14'h0000;
      ccuSrc_q <= 4'h0;
    end else begin
      flags_q  <= periphFlags;
      ccuSrc_q <= ccuSrc;
    end
  end

  // source s goes to node 10+k when its two pointer bits equal k
  logic [3:0] ccuNodeReq;
  genvar k;
  generate
    for (k = 0; k < `IPS_CCU_NODES; k++) begin : g_ccu
      wire [3:0] hit;
      assign hit[0] = ccuSrc_q[0] & (ccuPtr_q[1:0] == 2'(k));
      assign hit[1] = ccuSrc_q[1] & (ccuPtr_q[3:2] == 2'(k));
      assign hit[2] = ccuSrc_q[2] & (ccuPtr_q[5:4] == 2'(k));
      assign hit[3] = ccuSrc_q[3] & (ccuPtr_q[7:6] == 2'(k));
      assign ccuNodeReq[k] = |hit;
    end
  endgenerate

  // capture/compare requests join the four top nodes
  wire [13:0] nodeReq = flags_q | {ccuNodeReq, 10'h000};

  // ----------------------------------------------------------------------
  // non-maskable status flags
  // ----------------------------------------------------------------------
  logic [7:0] nmiStat;

  // set by source pulses, cleared only by writing ones
  sticky_w1c #(
    .W       (`IPS_NMI_SRCS)
  ) u_nmi_stat (
    .clk     (clk),
    .rstn    (rstnSync),
    .setBits (nmiEvent),
    .clrWr   (wrOk & selNmi),
    .clrBits (wrByte),
    .flags   (nmiStat)
  );

  // ----------------------------------------------------------------------
  // arbitration among maskable nodes
  // ----------------------------------------------------------------------
  logic   winValid;
  node_t  winNode;
  level_t winLevel;

  prio_arbiter u_arb (
    .req      (nodeReq),
    .lvlLow   (lvlLow),
    .lvlHigh  (lvlHigh),
    .winValid (winValid),
    .winNode  (winNode),
    .winLevel (winLevel)
  );

  // ----------------------------------------------------------------------
  // service tracking and presentation to the core
  // ----------------------------------------------------------------------
  logic [4:0]  active_q;
  logic        intReq_q;
  logic        nmiReq_q;
  node_t       intNode_q;
  level_t      intLevel_q;
  logic [13:0] vectorClr_q;

  // rank of the running service: 0 idle, level plus one, nmi on top
  rank_t runRank;
  logic [4:0] topOne;
  always_comb begin
    runRank = 3'h0;
    topOne  = 5'h00;
    for (int b = 0; b < 5; b++) begin
      if (active_q[b]) begin
        runRank = 3'(b + 1);
        topOne  = 5'h01 << b;
      end
    end
  end

  // pending request against the running rank, ack pushes, reti pops
  // equal level never pre-empts, so a held flag cannot re-enter itself
  wire   ackTake   = intAck & intReq_q;
  wire   nmiPend   = (|nmiStat) & ~active_q[4];
  wire   [2:0] winRank = {1'b0, winLevel} + 3'h1;
  wire   mskPend   = winValid & (winRank > runRank);
  wire   reqNext   = ~ackTake & (nmiPend | mskPend);
  wire   [4:0] ackOne = nmiReq_q ? 5'h10 : (5'h01 << intLevel_q);
  wire   [4:0] active_d = (active_q & ~(intReti ? topOne : 5'h00)) |
                          (ackTake ? ackOne : 5'h00);
  wire   [13:0] nodeOne = 14'h0001 << intNode_q;
  wire   autoClr   = ackTake & ~nmiReq_q;
  wire   [13:0] vectorClr_d = autoClr ?
                              (nodeOne & `IPS_AUTOCLR_MASK) : 14'h0000;
  wire   preempt   = ackTake & (runRank != 3'h0);

  // request registers, nmi chosen ahead of any level
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      active_q    <= 5'h00;
      intReq_q    <= 1'b0;
      nmiReq_q    <= 1'b0;
      intNode_q   <= 4'h0;
      intLevel_q  <= 2'h0;
      vectorClr_q <= 14'h0000;
    end else begin
      active_q    <= active_d;
      intReq_q    <= reqNext;
      nmiReq_q    <= reqNext & nmiPend;
      intNode_q   <= winNode;
      intLevel_q  <= winLevel;
      vectorClr_q <= vectorClr_d;
    end
  end

  // ----------------------------------------------------------------------
  // block interrupt: sticky events and mask
  // ----------------------------------------------------------------------
  logic [2:0] irqStat;
  logic       irq_q;
  wire  [2:0] irqEv;

  // event sources: vector taken, pre-emption, any nmi pulse
  assign irqEv[`IPS_EV_VECTOR]  = ackTake;
  assign irqEv[`IPS_EV_PREEMPT] = preempt;
  assign irqEv[`IPS_EV_NMI]     = |nmiEvent;

  sticky_w1c #(
    .W       (`IPS_IRQ_EVENTS)
  ) u_irq_stat (
    .clk     (clk),
    .rstn    (rstnSync),
    .setBits (irqEv),
    .clrWr   (wrOk & selIrqSt),
    .clrBits (wrByte[2:0]),
    .flags   (irqStat)
  );

  // level output while any unmasked event flag stands
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat & irqMask_q);
    end
  end

  // ----------------------------------------------------------------------
  // apb read mux and answer
  // ----------------------------------------------------------------------
  // core state word: active mask, presented node, request
  wire [31:0] coreWord = {15'h0000, intReq_q, 4'h0, intNode_q,
                          3'h0, active_q};
  wire [31:0] rdMux =
    selLoA   ? {26'h0000000, loA_q}     :
    selHiA   ? {26'h0000000, hiA_q}     :
    selLoB   ? {24'h000000, loB_q}      :
    selHiB   ? {24'h000000, hiB_q}      :
    selNmi   ? {24'h000000, nmiStat}    :
    selPtr   ? {24'h000000, ccuPtr_q}   :
    selIrqSt ? {29'h00000000, irqStat}  :
    selIrqMk ? {29'h00000000, irqMask_q} :
    selCore  ? coreWord                 : 32'h00000000;

  // one wait state, then ready with data and error flag
  always_ff @(posedge clk or negedge rstnSync) begin
    if (!rstnSync) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= accessPh & ~pready_q;
      prdata_q  <= (accessPh & ~pwrite) ? rdMux : 32'h00000000;
      pslverr_q <= accessPh & ~pready_q & ~mapped;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // every output is a copy of a flop
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign intReq    = intReq_q;
  assign nmiReq    = nmiReq_q;
  assign intNode   = intNode_q;
  assign intLevel  = intLevel_q;
  assign vectorClr = vectorClr_q;
  assign irq       = irq_q;

endmodule

// >>> src/prio_arbiter.sv
// picks the highest-level request, lowest node number on a tie
`timescale 1ns/10ps
module prio_arbiter
  import int_prio_pkg::*;
(
  // requests and their level bits
  input  wire logic [13:0] req,
  input  wire logic [13:0] lvlLow,
  input  wire logic [13:0] lvlHigh,
  // winner
  output      logic        winValid,
  output      node_t       winNode,
  output      level_t      winLevel
);

  // ----------------------------------------------------------------------
  // per-node level from the high and low bit
  // ----------------------------------------------------------------------
  level_t nodeLvl [14];
  genvar i;
  generate
    for (i = 0; i < 14; i++) begin : g_lvl
      assign nodeLvl[i] = {lvlHigh[i], lvlLow[i]};
    end
  endgenerate

  // scan down so that an equal level at a lower node replaces the pick
  always_comb begin
    winValid = 1'b0;
    winNode  = 4'h0;
    winLevel = 2'h0;
    for (int n = 13; n >= 0; n--) begin
      if (req[n] && (!winValid || nodeLvl[n] >= winLevel)) begin
        winValid = 1'b1;
        winNode  = 4'(n);
        winLevel = nodeLvl[n];
      end
    end
  end

endmodule

// >>> src/sticky_w1c.sv
// sticky flag bank, set by hardware pulses, cleared by writing ones
`timescale 1ns/10ps
module sticky_w1c
  import int_prio_pkg::*;
#(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // hardware set pulses
  input  wire logic [W-1:0] setBits,
  // software clear
  input  wire logic         clrWr,
  input  wire logic [W-1:0] clrBits,
  // flag state
  output      logic [W-1:0] flags
);

  // ----------------------------------------------------------------------
  // one flop per flag, set wins over a clear in the same cycle
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_flag
      logic flag_q;
      wire  flag_d = setBits[i] | (flag_q & ~(clrWr & clrBits[i]));
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= flag_d;
        end
      end
      assign flags[i] = flag_q;
    end
  endgenerate

endmodule

// >>> tb/core_model.sv
// processor core and peripheral flag model facing the priority select
`timescale 1ns/10ps
module core_model
  import int_prio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bench control
  input  wire logic [13:0] setEv,
  input  wire logic [13:0] clrEv,
  input  wire logic        ackEn,
  input  wire logic [3:0]  ackDly,
  // block side
  input  wire logic        intReq,
  input  wire logic [13:0] vectorClr,
  output      logic [13:0] periphFlags,
  output      logic        intAck
);
  logic [3:0] waitCnt;
  // flags set by events, dropped on vector or software clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      periphFlags <= 14'h0000;
    else
      periphFlags <= (periphFlags & ~vectorClr & ~clrEv) | setEv;
  end
  // core acknowledges a presented request after a set delay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitCnt <= 4'h0;
      intAck  <= 1'b0;
    end else begin
      waitCnt <= (intReq && !intAck) ? waitCnt + 4'h1 : 4'h0;
      intAck  <= ackEn && intReq && !intAck && waitCnt >= ackDly;
    end
  end
endmodule

// >>> tb/int_prio_select_sva.sv
// port assertions for the interrupt priority select
`timescale 1ns/10ps
`include "int_prio_params.svh"
module int_prio_select_sva
  import int_prio_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // requests
  input wire logic [13:0] periphFlags,
  input wire logic [3:0]  ccuSrc,
  input wire logic [7:0]  nmiEvent,
  // core side
  input wire logic        intReq,
  input wire logic        nmiReq,
  input wire node_t       intNode,
  input wire level_t      intLevel,
  input wire logic        intAck,
  input wire logic        intReti,
  input wire logic [13:0] vectorClr,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic [13:0] loS_q;
  logic [13:0] hiS_q;
  logic [13:0] flg1_q;
  logic [13:0] flg2_q;
  logic        wrOk;
  logic        nmiAct_q;
  // accepted write of a mapped register
  assign wrOk = psel & penable & pready & pwrite & pstrb[0] & ~pslverr;
  // shadow level bits, source flags two samples back, nmi in service
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loS_q  <= 14'h0000;
      hiS_q  <= 14'h0100;
      flg1_q <= 14'h0000;
      flg2_q <= 14'h0000;
      nmiAct_q <= 1'b0;
    end else begin
      flg1_q <= periphFlags;
      nmiAct_q <= (nmiAct_q & ~intReti) | (intReq & intAck & nmiReq);
      flg2_q <= flg1_q;
      if (wrOk && paddr == `IPS_ADDR_LO_A) loS_q[5:0] <= pwdata[5:0];
      if (wrOk && paddr == `IPS_ADDR_HI_A) hiS_q[5:0] <= pwdata[5:0];
      if (wrOk && paddr == `IPS_ADDR_LO_B) loS_q[13:6] <= pwdata[7:0];
      if (wrOk && paddr == `IPS_ADDR_HI_B) hiS_q[13:6] <= pwdata[7:0];
    end
  end

  sequence oneWait;
    !pready ##1 pready;
  endsequence

  // nmi event while no nmi runs and no ack is taken next cycle
  sequence nmiNoAck;
    (nmiEvent != 8'h00 && !nmiReq && !nmiAct_q) ##1 !(intReq && intAck);
  endsequence

  a_one_wait: assert property ($rose(penable) && psel |-> oneWait)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without zero data");
  a_rsvd_zero: assert property
    (pready && !pwrite && (paddr == `IPS_ADDR_LO_A
     || paddr == `IPS_ADDR_HI_A) |-> prdata[7:6] == 2'h0)
    else $error("reserved bits set");
  a_nmi_top: assert property (nmiReq |-> intReq)
    else $error("nmi without request");
  a_nmi_wins: assert property (nmiNoAck |=> nmiReq)
    else $error("nmi not presented over level request");
  a_ack_drop: assert property (intReq && intAck |=> !intReq)
    else $error("request kept after ack");
  a_lvl_map: assert property
    (intReq && !nmiReq |-> intLevel == {hiS_q[intNode], loS_q[intNode]})
    else $error("level mismatch");
  a_flag_src: assert property
    (intReq && !nmiReq && intNode < 4'hA |-> flg2_q[intNode])
    else $error("request without flag");
  a_clr_vec: assert property
    (intReq && intAck && !nmiReq && intNode < 4'h4
     |=> vectorClr == (14'h0001 << $past(intNode)))
    else $error("vector clear missing");
  a_clr_only: assert property
    (vectorClr != 14'h0 |-> $past(intReq) && $past(intAck)
     && !$past(nmiReq) && vectorClr[13:4] == 10'h0)
    else $error("stray vector clear");
endmodule

// >>> tb/tb.sv
// self-checking bench for the interrupt priority select
`timescale 1ns/10ps
`include "int_prio_params.svh"
module tb
  import int_prio_pkg::*;
;
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, er;
  logic        intReq, nmiReq, intAck, intReti, irq, ackEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, ccuSrc, ackDly;
  logic [13:0] periphFlags, setEv, clrEv, vectorClr;
  logic [7:0]  nmiEvent;
  node_t       intNode;
  level_t      intLevel;
  int          err_count, total_checks;

  int_prio_select i_dut (.clk, .rstn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .periphFlags, .ccuSrc,
    .nmiEvent, .intReq, .nmiReq, .intNode, .intLevel, .intAck, .intReti,
    .vectorClr, .irq);
  core_model i_core (.clk, .rstn, .setEv, .clrEv, .ackEn, .ackDly,
    .intReq, .vectorClr, .periphFlags, .intAck);

  // free running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task apb(input bit w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(n < 20, "apb timeout");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wait_req(input bit nmi, input logic [3:0] nd, input logic [1:0] lv);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((intReq !== 1'b1 || nmiReq !== nmi) && n < 40);
    chk(n < 40, "no request");
    if (!nmi) chk(intNode === nd && intLevel === lv, "node or level");
  endtask

  task pulse(input logic [13:0] s, input logic [13:0] c);
    setEv <= s;
    clrEv <= c;
    @(posedge clk);
    setEv <= 14'h0;
    clrEv <= 14'h0;
    @(posedge clk);
  endtask

  task reti;
    intReti <= 1'b1;
    @(posedge clk);
    intReti <= 1'b0;
    @(posedge clk);
  endtask

  task setlv(input logic [13:0] lo, input logic [13:0] hi);
    apb(1, `IPS_ADDR_LO_A, {2'h0, lo[5:0]});
    apb(1, `IPS_ADDR_HI_A, {2'h0, hi[5:0]});
    apb(1, `IPS_ADDR_LO_B, lo[13:6]);
    apb(1, `IPS_ADDR_HI_B, hi[13:6]);
  endtask

  task t_regs;
    logic [11:0] ad [8];
    logic [7:0]  ex [8];
    ad = '{`IPS_ADDR_LO_A, `IPS_ADDR_HI_A, `IPS_ADDR_LO_B, `IPS_ADDR_HI_B,
      `IPS_ADDR_CCU_PTR, `IPS_ADDR_IRQ_MASK, `IPS_ADDR_IRQ_STAT,
      `IPS_ADDR_NMI_STAT};
    ex = '{8'h00, 8'h00, 8'h00, 8'h04, 8'hE4, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      apb(0, ad[i], 8'h00);
      chk(rd === {24'h0, ex[i]}, "reset value");
    end
    apb(1, `IPS_ADDR_LO_A, 8'hFF);
    apb(0, `IPS_ADDR_LO_A, 8'h00);
    chk(rd === 32'h3F, "reserved bits");
    pstrb <= 4'h0;
    apb(1, `IPS_ADDR_LO_A, 8'h00);
    pstrb <= 4'h1;
    apb(0, `IPS_ADDR_LO_A, 8'h00);
    chk(rd === 32'h3F, "write without strobe");
    apb(0, 12'h010, 8'h00);
    chk(er === 1'b1 && rd === 32'h0, "unmapped");
  endtask

  task t_nodes;
    logic [13:0] b;
    logic [1:0]  l;
    for (int n = 0; n < 14; n++) begin
      b = 14'h0001 << n;
      l = 2'(n % 4);
      ackDly <= 4'(n % 3);
      setlv(l[0] ? b : 14'h0, l[1] ? b : 14'h0);
      pulse(b, 14'h0);
      wait_req(0, 4'(n), l);
      repeat (6) @(posedge clk);
      chk(periphFlags[n] === (n > 3), "vector clear");
      pulse(14'h0, b);
      reti;
    end
    ackDly <= 4'h0;
  endtask

  task t_order;
    setlv(14'h1088, 14'h1000);
    pulse(14'h0088, 14'h0);
    wait_req(0, 4'h3, 2'h1);
    repeat (2) @(posedge clk);
    repeat (8) begin
      @(posedge clk);
      chk(intReq === 1'b0, "equal level presented");
    end
    pulse(14'h1000, 14'h0);
    wait_req(0, 4'hC, 2'h3);
    repeat (3) @(posedge clk);
    apb(0, `IPS_ADDR_CORE, 8'h00);
    chk(rd === 32'h00000C0A, "core state word");
    pulse(14'h0, 14'h1000);
    reti;
    reti;
    wait_req(0, 4'h7, 2'h1);
    repeat (3) @(posedge clk);
    pulse(14'h0, 14'h0080);
    reti;
  endtask

  task t_nmi;
    ackEn <= 1'b0;
    pulse(14'h1000, 14'h0);
    wait_req(0, 4'hC, 2'h3);
    for (int k = 0; k < 8; k++) begin
      nmiEvent <= 8'h01 << k;
      @(posedge clk);
      nmiEvent <= 8'h00;
      wait_req(1, 4'h0, 2'h0);
      apb(0, `IPS_ADDR_NMI_STAT, 8'h00);
      chk(rd === 32'(8'h01 << k), "nmi flag");
      apb(1, `IPS_ADDR_NMI_STAT, 8'h01 << k);
      wait_req(0, 4'hC, 2'h3);
    end
    ackEn <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(14'h0, 14'h1000);
    reti;
  endtask

  task t_irq;
    chk(irq === 1'b0, "irq while masked");
    apb(1, `IPS_ADDR_IRQ_MASK, 8'h02);
    repeat (2) @(posedge clk);
    chk(irq === 1'b1, "irq unmasked");
    apb(0, `IPS_ADDR_IRQ_STAT, 8'h00);
    chk(rd === 32'h7, "irq status");
    apb(1, `IPS_ADDR_IRQ_STAT, 8'h02);
    repeat (2) @(posedge clk);
    chk(irq === 1'b0, "irq cleared");
  endtask

  task t_ccu;
    setlv(14'h0, 14'h0);
    apb(1, `IPS_ADDR_CCU_PTR, 8'h1B);
    for (int s = 0; s < 4; s++) begin
      ccuSrc <= 4'h1 << s;
      wait_req(0, 4'(13 - s), 2'h0);
      ccuSrc <= 4'h0;
      repeat (3) @(posedge clk);
      reti;
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    {rstn, psel, penable, pwrite, intReti} = 5'h00;
    {paddr, pwdata, ccuSrc, nmiEvent, setEv, clrEv} = '0;
    {pstrb, ackEn, ackDly} = 9'h030;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_nodes;
    t_order;
    t_nmi;
    t_irq;
    t_ccu;
    end_sim;
  end

  // watchdog against a hang
  initial begin
    #40000;
    err_count++;
    $display("[ERR] %0t watchdog", $time);
    end_sim;
  end
endmodule

bind int_prio_select int_prio_select_sva i_sva (.clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
  .periphFlags, .ccuSrc, .nmiEvent, .intReq, .nmiReq, .intNode, .intLevel,
  .intAck, .intReti, .vectorClr, .irq);
